/* rtl/i2c_irq_params.svh */
// Offsets, field positions, reset values and sizes for the two-wire
// interrupt status, clear and data hold block.
// Assumes a byte-addressed view: byte offsets on a 32-bit bus.
`ifndef I2C_IRQ_PARAMS_SVH
`define I2C_IRQ_PARAMS_SVH

// Register byte offsets
`define OFS_TX_THRESHOLD 8'h10
`define OFS_RX_THRESHOLD 8'h14
`define OFS_IRQ_ENABLE 8'h2c
`define OFS_RAW_STATUS 8'h30
`define OFS_MASKED_STATUS 8'h34
`define OFS_IRQ_CLEAR 8'h38
`define OFS_DATA_HOLD 8'h4c

// Status bit positions
`define BIT_TX_EMPTY 0
`define BIT_TX_NEARLY_EMPTY 1
`define BIT_TX_FULL 2
`define BIT_TX_OVERRUN 3
`define BIT_RX_EMPTY 4
`define BIT_RX_NEARLY_FULL 5
`define BIT_RX_FULL 6
`define BIT_SLV_READ_REQ 16
`define BIT_SLV_READ_EMPTY 17
`define BIT_SLV_WRITE_REQ 18
`define BIT_MASTER_DONE 19
`define BIT_SLAVE_DONE 20
`define BIT_ARB_LOST 24
`define BIT_BUS_ERROR 25
`define BIT_MASTER_DONE_NOSTOP 28

// Bits that latch and are cleared by a one in the clear register
`define STICKY_MASK 32'h131f0008

// Reset values
`define RST_DATA_HOLD 9'h014
`define RST_THRESHOLD 5'h00
`define RST_IRQ_ENABLE 32'h00000000

// FIFO depth in entries and the width of an entry count
`define FIFO_DEPTH 5'h10
`define CNT_W 5
`define HOLD_W 9

`endif

/* rtl/i2c_irq_pkg.sv */
// Types shared by the two-wire interrupt and data hold block.
// Assumes the params header is included by users needing numbers.
package i2c_irq_pkg;
  // Data hold counter phases
  typedef enum logic [0:0] {
    HOLD_IDLE,
    HOLD_COUNT
  } hold_state_e;

  // Arbitration recovery phases
  typedef enum logic [0:0] {
    ARB_NORMAL,
    ARB_WAIT_STOP
  } arb_state_e;
endpackage

/* rtl/i2c_irq_status_clear_hold.sv */
// Interrupt status, write-one clear and data hold timing of a two-wire
// serial controller acting as master or slave.
// Assumes an Avalon-MM master on SYS_CLK and a transfer engine that
// supplies FIFO counts, event pulses and the next data bit.
//
// Added by the designer: the Avalon-MM register port.
`timescale 1ns/100ps
`include "i2c_irq_params.svh"

module i2c_irq_status_clear_hold
  import i2c_irq_pkg::*;
(
  // Clock and reset
  input wire logic SYS_CLK,
  input wire logic NRST,
  // Avalon-MM register slave
  input wire logic [7:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  // FIFO occupancy from the transfer engine
  input wire logic [4:0] TX_FIFO_COUNT,
  input wire logic [4:0] RX_FIFO_COUNT,
  // Event pulses and levels from the transfer engine
  input wire logic TX_OVERRUN,
  input wire logic SLV_READ_REQ,
  input wire logic SLV_READ_ACTIVE,
  input wire logic SLV_WRITE_REQ,
  input wire logic MASTER_DONE,
  input wire logic SLAVE_DONE,
  input wire logic ARB_LOST,
  input wire logic BUS_ERROR,
  input wire logic MASTER_DONE_NOSTOP,
  // Data the engine wants on the data line
  input wire logic TX_DRIVE,
  input wire logic TX_BIT,
  // Serial lines
  input wire logic SCL_I,
  input wire logic SDA_I,
  output logic SDA_O,
  output logic SDA_OE,
  // Engine handshakes
  output logic DATA_SHIFT,
  output logic MASTER_OP_ALLOW,
  output logic ARB_RETRY_OK
);

  // Avalon handshake and register state
  logic ack_r;
  logic [31:0] rdata_r;
  logic [`CNT_W-1:0] tx_thr_r;
  logic [`CNT_W-1:0] rx_thr_r;
  logic [31:0] enable_r;
  logic [`HOLD_W-1:0] hold_r;
  logic [31:0] sticky_r;
  logic [31:0] sticky_nxt;
  logic [31:0] raw_status;
  logic [31:0] masked_status;
  logic wr_take;
  logic rd_take;
  logic [31:0] clr_mask;
  // Serial line synchronisers and derived events
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic scl_lvl_r;
  logic sda_lvl_r;
  logic scl_fall;
  logic stop_seen;
  // Hold counter
  hold_state_e hold_st_r;
  logic [`HOLD_W-1:0] hold_cnt_r;
  logic shift_r;
  logic sda_drive_r;
  // Arbitration recovery
  arb_state_e arb_st_r;

  // Full test used for both FIFOs
  function automatic logic fifo_full(input logic [`CNT_W-1:0] cnt);
    fifo_full = (cnt >= `FIFO_DEPTH);
  endfunction

  // Bus access is taken on the edge where waitrequest is low
  assign wr_take = AVS_WRITE & ack_r;
  assign rd_take = AVS_READ & ack_r;
  assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_r;
  assign AVS_READDATA = rdata_r;

  // One wait cycle per access, so read data can come from a flop
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (AVS_READ | AVS_WRITE) & ~ack_r;
    end
  end

  // Software control registers
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      tx_thr_r <= `RST_THRESHOLD;
      rx_thr_r <= `RST_THRESHOLD;
      enable_r <= `RST_IRQ_ENABLE;
      hold_r <= `RST_DATA_HOLD;
    end else if (wr_take) begin
      if (AVS_ADDRESS == `OFS_TX_THRESHOLD) begin
        tx_thr_r <= AVS_WRITEDATA[`CNT_W-1:0];
      end else if (AVS_ADDRESS == `OFS_RX_THRESHOLD) begin
        rx_thr_r <= AVS_WRITEDATA[`CNT_W-1:0];
      end else if (AVS_ADDRESS == `OFS_IRQ_ENABLE) begin
        enable_r <= AVS_WRITEDATA & (`STICKY_MASK | 32'h0000007f);
      end else if (AVS_ADDRESS == `OFS_DATA_HOLD) begin
        hold_r <= AVS_WRITEDATA[`HOLD_W-1:0];
      end
    end
  end

  // Write-one clear; only the latched positions respond
  assign clr_mask = (wr_take && AVS_ADDRESS == `OFS_IRQ_CLEAR) ?
                    (AVS_WRITEDATA & `STICKY_MASK) : 32'h00000000;

  // Latched events; a new event in the clear cycle survives the clear
  always_comb begin
    sticky_nxt = sticky_r & ~clr_mask;
    if (TX_OVERRUN) begin
      sticky_nxt[`BIT_TX_OVERRUN] = 1'b1;
    end
    if (SLV_READ_REQ) begin
      sticky_nxt[`BIT_SLV_READ_REQ] = 1'b1;
    end
    if (SLV_READ_ACTIVE && TX_FIFO_COUNT == 5'h00) begin
      sticky_nxt[`BIT_SLV_READ_EMPTY] = 1'b1;
    end
    if (SLV_WRITE_REQ) begin
      sticky_nxt[`BIT_SLV_WRITE_REQ] = 1'b1;
    end
    if (MASTER_DONE) begin
      sticky_nxt[`BIT_MASTER_DONE] = 1'b1;
    end
    if (SLAVE_DONE) begin
      sticky_nxt[`BIT_SLAVE_DONE] = 1'b1;
    end
    if (ARB_LOST) begin
      sticky_nxt[`BIT_ARB_LOST] = 1'b1;
    end
    if (BUS_ERROR) begin
      sticky_nxt[`BIT_BUS_ERROR] = 1'b1;
    end
    if (MASTER_DONE_NOSTOP) begin
      sticky_nxt[`BIT_MASTER_DONE_NOSTOP] = 1'b1;
    end
  end

  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      sticky_r <= 32'h00000000;
    end else begin
      sticky_r <= sticky_nxt;
    end
  end

  // Level bits follow the counts live and never latch
  always_comb begin
    raw_status = sticky_r;
    raw_status[`BIT_TX_EMPTY] = (TX_FIFO_COUNT == 5'h00);
    raw_status[`BIT_TX_NEARLY_EMPTY] = (TX_FIFO_COUNT <= tx_thr_r);
    raw_status[`BIT_TX_FULL] = fifo_full(TX_FIFO_COUNT);
    raw_status[`BIT_RX_EMPTY] = (RX_FIFO_COUNT == 5'h00);
    raw_status[`BIT_RX_NEARLY_FULL] = (RX_FIFO_COUNT >= rx_thr_r);
    raw_status[`BIT_RX_FULL] = fifo_full(RX_FIFO_COUNT);
  end

  assign masked_status = raw_status & enable_r;

  // Read mux; unmapped and write-only offsets read zero
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      rdata_r <= 32'h00000000;
    end else if (AVS_READ && !ack_r) begin
      if (AVS_ADDRESS == `OFS_TX_THRESHOLD) begin
        rdata_r <= {27'h0000000, tx_thr_r};
      end else if (AVS_ADDRESS == `OFS_RX_THRESHOLD) begin
        rdata_r <= {27'h0000000, rx_thr_r};
      end else if (AVS_ADDRESS == `OFS_IRQ_ENABLE) begin
        rdata_r <= enable_r;
      end else if (AVS_ADDRESS == `OFS_RAW_STATUS) begin
        rdata_r <= raw_status;
      end else if (AVS_ADDRESS == `OFS_MASKED_STATUS) begin
        rdata_r <= masked_status;
      end else if (AVS_ADDRESS == `OFS_DATA_HOLD) begin
        rdata_r <= {23'h000000, hold_r};
      end else begin
        rdata_r <= 32'h00000000;
      end
    end
  end

  // Three-stage synchronisers for the serial lines
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], SCL_I};
      sda_sync_r <= {sda_sync_r[1:0], SDA_I};
    end
  end

  // Filtered levels change only when the last two stages agree
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      scl_lvl_r <= 1'b1;
      sda_lvl_r <= 1'b1;
    end else begin
      if (scl_sync_r[2] == scl_sync_r[1]) begin
        scl_lvl_r <= scl_sync_r[2];
      end
      if (sda_sync_r[2] == sda_sync_r[1]) begin
        sda_lvl_r <= sda_sync_r[2];
      end
    end
  end

  assign scl_fall = scl_lvl_r & (scl_sync_r[2] == scl_sync_r[1]) &
                    ~scl_sync_r[2];
  // Stop: data rises while clock stays high
  assign stop_seen = scl_lvl_r & ~sda_lvl_r &
                     (sda_sync_r[2] == sda_sync_r[1]) & sda_sync_r[2];

  // Hold counter; a new falling edge restarts it from zero
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      hold_st_r <= HOLD_IDLE;
      hold_cnt_r <= 9'h000;
      shift_r <= 1'b0;
    end else begin
      shift_r <= 1'b0;
      case (hold_st_r)
        HOLD_IDLE: begin
          if (scl_fall) begin
            hold_st_r <= HOLD_COUNT;
            hold_cnt_r <= 9'h000;
          end
        end
        HOLD_COUNT: begin
          if (scl_fall) begin
            hold_cnt_r <= 9'h000;
          end else if (hold_cnt_r >= hold_r) begin
            hold_st_r <= HOLD_IDLE;
            shift_r <= 1'b1;
          end else begin
            hold_cnt_r <= hold_cnt_r + 9'h001;
          end
        end
        default: begin
          hold_st_r <= HOLD_IDLE;
        end
      endcase
    end
  end

  // Arbitration loss parks the bus until a stop is seen
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      arb_st_r <= ARB_NORMAL;
    end else begin
      case (arb_st_r)
        ARB_NORMAL: begin
          if (ARB_LOST) begin
            arb_st_r <= ARB_WAIT_STOP;
          end
        end
        ARB_WAIT_STOP: begin
          if (stop_seen) begin
            arb_st_r <= ARB_NORMAL;
          end
        end
        default: begin
          arb_st_r <= ARB_NORMAL;
        end
      endcase
    end
  end

  // Data line changes only at the hold point; released after a loss
  always_ff @(posedge SYS_CLK) begin
    if (!NRST) begin
      sda_drive_r <= 1'b0;
    end else if (ARB_LOST || arb_st_r == ARB_WAIT_STOP) begin
      sda_drive_r <= 1'b0;
    end else if (shift_r) begin
      sda_drive_r <= TX_DRIVE & ~TX_BIT;
    end
  end

  // Open drain: only ever pulls low
  assign SDA_O = 1'b0;
  assign SDA_OE = sda_drive_r;
  assign DATA_SHIFT = shift_r;
  assign ARB_RETRY_OK = (arb_st_r == ARB_NORMAL);
  // Blocks the next master op until the no-stop completion is cleared
  assign MASTER_OP_ALLOW = ~sticky_r[`BIT_MASTER_DONE_NOSTOP];

endmodule

/* dv/i2c_irq_status_clear_hold_asserts.sv */
// Checker for the interrupt status, clear and data hold block.
// Assumes binding to the block; it sees only the block's ports.
`timescale 1ns/100ps
module i2c_irq_status_clear_hold_asserts (
  // Clock, reset and bus
  input wire logic SYS_CLK,
  input wire logic NRST,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic AVS_WAITREQUEST,
  // Engine side
  input wire logic ARB_LOST,
  input wire logic MASTER_DONE_NOSTOP,
  input wire logic TX_DRIVE,
  input wire logic TX_BIT,
  input wire logic SDA_OE,
  input wire logic DATA_SHIFT,
  input wire logic MASTER_OP_ALLOW,
  input wire logic ARB_RETRY_OK
);
  default clocking @(posedge SYS_CLK);
  endclocking
  default disable iff (!NRST);
  // Clear writes depend on the fixed single wait
  AST_ONE_WAIT: assert property (
    (AVS_READ || AVS_WRITE) && !$past(AVS_READ || AVS_WRITE)
    |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST) else $error("bad wait");
  AST_ARB_RELEASE: assert property (
    ARB_LOST |=> !SDA_OE) else $error("bus kept after lost arb");
  AST_ARB_WAIT: assert property (
    ARB_LOST |=> !ARB_RETRY_OK) else $error("retry allowed too soon");
  AST_NOSTOP_BLOCK: assert property (
    MASTER_DONE_NOSTOP |=> !MASTER_OP_ALLOW) else $error("op not held");
  AST_SHIFT_PULSE: assert property (
    DATA_SHIFT |=> !DATA_SHIFT) else $error("shift longer than 1");
  AST_OE_FOLLOW: assert property (
    DATA_SHIFT && !ARB_LOST && ARB_RETRY_OK
    |=> SDA_OE == $past(TX_DRIVE && !TX_BIT))
    else $error("data not updated");
  AST_OE_RISE: assert property (
    $rose(SDA_OE) |-> $past(DATA_SHIFT)) else $error("early data");
  AST_OE_FALL: assert property (
    $fell(SDA_OE) |-> $past(DATA_SHIFT) || $past(ARB_LOST))
    else $error("data dropped early");
  // Main scenarios reached
  cover property (DATA_SHIFT);
  cover property (ARB_LOST ##1 !ARB_RETRY_OK);
  cover property (MASTER_DONE_NOSTOP ##1 !MASTER_OP_ALLOW);
endmodule

bind i2c_irq_status_clear_hold i2c_irq_status_clear_hold_asserts chk (
  .SYS_CLK, .NRST, .AVS_READ, .AVS_WRITE, .AVS_WAITREQUEST, .ARB_LOST,
  .MASTER_DONE_NOSTOP, .TX_DRIVE, .TX_BIT, .SDA_OE, .DATA_SHIFT,
  .MASTER_OP_ALLOW, .ARB_RETRY_OK);

/* dv/i2c_link_model.sv */
// Far-side two-wire station: clock frames and stop conditions.
// Assumes pull-ups on both lines; the block pulls data via sda_oe.
`timescale 1ns/100ps
module i2c_link_model (
  // Block side
  input wire logic sda_oe,
  // Lines
  output logic scl,
  output logic sda
);
  logic sda_low_r = 1'h0;
  // Open drain: pull-up wins unless someone pulls low
  assign sda = !(sda_oe || sda_low_r);
  initial scl = 1'h1; // Stands high between frames
  // Clock of 64 ns period, only inside a frame
  task automatic frame(input int n);
    #1; // Keep pin edges off the sampling clock edge
    repeat (n) begin
      #32 scl = 1'h0;
      #32 scl = 1'h1;
    end
  endtask
  // Data rises while clock high
  task automatic stop_cond();
    #1 sda_low_r = 1'h0;
    #16 sda_low_r = 1'h1;
    #16 sda_low_r = 1'h0;
  endtask
endmodule

/* dv/i2c_irq_status_clear_hold_test.sv */
// Bench for the interrupt status, clear and data hold block.
// Assumes the link model on the serial pins and bus timing of the note.
`timescale 1ns/100ps
`include "i2c_irq_params.svh"
module i2c_irq_status_clear_hold_test;
  logic clk = 1'h0, nrst = 1'h0, rd = 1'h0, wr = 1'h0, wrq, scl, sda;
  logic txd = 1'h0, txb = 1'h0, oe, shift, allow, retry;
  logic [7:0] adr = 8'h0;
  logic [31:0] wdat = 32'h0, rdat, rv;
  logic [4:0] txc = 5'h0, rxc = 5'h0;
  logic [8:0] ev = 9'h0;
  int err_total = 0, total_checks = 0, n;
  int pos[9] = '{3, 16, 18, 19, 20, 24, 25, 28, 17};
  logic [4:0] tl[5] = '{5'h0, 5'h4, 5'h5, 5'h10, 5'h3};
  logic [4:0] rl[5] = '{5'h0, 5'h4, 5'h3, 5'h10, 5'h10};
  i2c_irq_status_clear_hold uut (
    .SYS_CLK(clk), .NRST(nrst), .AVS_ADDRESS(adr), .AVS_READ(rd),
    .AVS_WRITE(wr), .AVS_WRITEDATA(wdat), .AVS_READDATA(rdat),
    .AVS_WAITREQUEST(wrq), .TX_FIFO_COUNT(txc), .RX_FIFO_COUNT(rxc),
    .TX_OVERRUN(ev[0]), .SLV_READ_REQ(ev[1]), .SLV_WRITE_REQ(ev[2]),
    .MASTER_DONE(ev[3]), .SLAVE_DONE(ev[4]), .ARB_LOST(ev[5]),
    .BUS_ERROR(ev[6]), .MASTER_DONE_NOSTOP(ev[7]), .SLV_READ_ACTIVE(ev[8]),
    .TX_DRIVE(txd), .TX_BIT(txb), .SCL_I(scl), .SDA_I(sda), .SDA_O(),
    .SDA_OE(oe), .DATA_SHIFT(shift), .MASTER_OP_ALLOW(allow),
    .ARB_RETRY_OK(retry));
  i2c_link_model link (.sda_oe(oe), .scl(scl), .sda(sda));
  initial forever #2 clk = ~clk;
  // Hang guard well above the expected run
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    report_and_stop();
  end
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %0t seen %h exp %h", $time, s, e);
    end
  endtask
  // One bus access; held until waitrequest is seen low at an edge
  task automatic acc(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (wrq !== 1'h0);
    rv = rdat;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask
  // Level bits expected with thresholds of 4
  function automatic logic [31:0] lvl(input logic [4:0] t, r);
    lvl = {25'h0, r == 5'h10, r >= 5'h4, r == 5'h0, 1'h0,
           t == 5'h10, t <= 5'h4, t == 5'h0};
  endfunction
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'h1;
    acc(1'h0, `OFS_DATA_HOLD, 32'h0);
    chk(rv, 32'h14);
    acc(1'h0, `OFS_MASKED_STATUS, 32'h0);
    chk(rv, 32'h0);
    acc(1'h0, 8'h40, 32'h0);
    chk(rv, 32'h0);
    acc(1'h1, `OFS_IRQ_ENABLE, 32'hffffffff);
    acc(1'h1, `OFS_TX_THRESHOLD, 32'h4);
    acc(1'h1, `OFS_RX_THRESHOLD, 32'h4);
    // Levels must follow counts both ways, no latching
    for (int i = 0; i < 5; i++) begin
      txc <= tl[i];
      rxc <= rl[i];
      acc(1'h0, `OFS_MASKED_STATUS, 32'h0);
      chk(rv, lvl(tl[i], rl[i]));
    end
    // Each event latches, survives zero writes, clears on a one
    for (int i = 0; i < 9; i++) begin
      @(posedge clk);
      ev[i] <= 1'h1;
      txc <= (i == 8) ? 5'h0 : 5'h5;
      rxc <= 5'h5;
      @(posedge clk);
      ev[i] <= 1'h0;
      txc <= 5'h5;
      acc(1'h1, `OFS_IRQ_CLEAR, ~(32'h1 << pos[i]));
      acc(1'h0, `OFS_MASKED_STATUS, 32'h0);
      chk(rv, 32'h20 | (32'h1 << pos[i]));
      if (i == 7) chk(32'(allow), 32'h0);
      if (i == 5) chk(32'(retry), 32'h0);
      acc(1'h1, `OFS_IRQ_CLEAR, 32'h1 << pos[i]);
      acc(1'h0, `OFS_MASKED_STATUS, 32'h0);
      chk(rv, 32'h20);
      if (i == 7) chk(32'(allow), 32'h1);
    end
    // Only enabled sources show through
    acc(1'h1, `OFS_IRQ_ENABLE, 32'h8);
    @(posedge clk);
    ev <= 9'h0df;
    @(posedge clk);
    ev <= 9'h0;
    acc(1'h0, `OFS_MASKED_STATUS, 32'h0);
    chk(rv, 32'h8);
    acc(1'h1, `OFS_DATA_HOLD, 32'hffffffff);
    acc(1'h0, `OFS_DATA_HOLD, 32'h0);
    chk(rv, 32'h1ff);
    acc(1'h1, `OFS_DATA_HOLD, 32'h3);
    // Release the parked bus first so the data line is really driven
    link.stop_cond();
    repeat (10) @(posedge clk);
    chk(32'(retry), 32'h1);
    txd <= 1'h1;
    // Data moves only after the hold count from each clock fall
    fork
      link.frame(4);
    join_none
    for (int k = 0; k < 4; k++) begin
      @(negedge scl);
      n = 0;
      do begin
        @(posedge clk);
        n++;
      end while (shift !== 1'h1 && n < 40);
      chk(32'(n >= 6 && n <= 10), 32'h1);
      @(posedge clk);
      chk(32'(oe), 32'(k < 3));
      if (k == 2) txb <= 1'h1;
    end
    repeat (20) @(posedge clk);
    report_and_stop();
  end
endmodule
